// *** hw/spi_switch_control_port.sv ***
`timescale 1ns/1ps
// Serial control port with open-before-close switch driver.
// The serial clock is oversampled by the core clock, so the link clock
// must stay below a quarter of the core rate in practice.
module spi_switch_control_port #(
  parameter int N_SW    = 8,                          // Switch count
  parameter int GAP_CYC = spi_sw_pkg::OPEN_GAP_CYC    // Open-to-close gap
) (
  // Core clock and reset (reset comes from the reset/supply pin)
  input  wire logic                i_core_clk,
  input  wire logic                i_resetn,
  // Serial pins
  input  wire logic                i_sclk,
  input  wire logic                i_cs_n,
  input  wire logic                i_sdi,
  output logic                     o_sdo,
  output logic                     o_sdo_oe_n,
  // Switch drives
  output logic [N_SW-1:0]          o_switch_on,
  // Status
  output spi_sw_pkg::err_type      o_err_flags,
  output spi_sw_pkg::err_type      o_err_cfg,
  output logic                     o_burst_mode,
  output logic                     o_daisy_mode,
  output logic                     o_switch_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: pattern and gap counter are both 8 bits wide
  if (N_SW < 1 || N_SW > 8) begin : g_bad_n_sw
    $error("N_SW must be 1..8");
  end
  if (GAP_CYC < 1 || GAP_CYC > 255) begin : g_bad_gap
    $error("GAP_CYC must be 1..255");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  spi_sw_pkg::pins_type pins_s;        // Synchronised pins
  spi_sw_pkg::pins_type pins_raw;      // Raw pins
  localparam logic [2:0] PIN_RST = 3'h2;  // Clock low, select idle

  assign pins_raw = '{sclk: i_sclk, cs_n: i_cs_n, sdi: i_sdi};

  sync_bits #(
    .W       (3),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_async    (pins_raw),
    .o_sync     (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial state
  logic        sclk_d_r, sclk_d_nxt;     // Previous synced clock
  logic        cs_d_r,   cs_d_nxt;       // Previous synced select
  logic [4:0]  cnt_r,    cnt_nxt;        // Bits in current command
  logic [1:0]  ncmd_r,   ncmd_nxt;       // Commands in frame, saturates
  logic [23:0] sh_r,     sh_nxt;         // Input shift register
  logic [7:0]  out_r,    out_nxt;        // Output shift register
  logic        sdo_r,    sdo_nxt;        // Serial output bit
  spi_sw_pkg::cmd_type pend_r, pend_nxt; // Address-mode held write
  logic        pend_v_r, pend_v_nxt;
  spi_sw_pkg::err_type cfg_r, cfg_nxt;   // Error check enables
  spi_sw_pkg::err_type flg_r, flg_nxt;   // Sticky error flags
  logic        burst_r,  burst_nxt;
  logic        daisy_r,  daisy_nxt;
  logic [7:0]  tgt_r,    tgt_nxt;        // Commanded switch pattern
  logic        tgt_new;                  // Pulse: new pattern written

  // Edge detection on the second synchroniser stage only
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic sel;
  assign sel     = ~pins_s.cs_n;
  assign rise    = sel & pins_s.sclk & ~sclk_d_r;
  assign fall    = sel & ~pins_s.sclk & sclk_d_r;
  assign cs_fall = ~pins_s.cs_n & cs_d_r;
  assign cs_rise = pins_s.cs_n & ~cs_d_r;

  // Command length follows chain mode first, then the checksum enable
  logic [4:0] flen;
  always_comb begin
    if (daisy_r) begin
      flen = 5'(spi_sw_pkg::DAISY_BITS);
    end else if (cfg_r.crc) begin
      flen = 5'(spi_sw_pkg::CMD_BITS + spi_sw_pkg::CRC_BITS);
    end else begin
      flen = 5'(spi_sw_pkg::CMD_BITS);
    end
  end

  // Address map check
  function automatic logic addr_ok(input logic [6:0] a);
    return a == spi_sw_pkg::ADDR_SWITCH  || a == spi_sw_pkg::ADDR_ERR_CFG ||
           a == spi_sw_pkg::ADDR_ERR_FLG || a == spi_sw_pkg::ADDR_BURST   ||
           a == spi_sw_pkg::ADDR_DAISY;
  endfunction : addr_ok

  // Read-back mux; unmapped reads return zero
  function automatic logic [7:0] rd_data(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      spi_sw_pkg::ADDR_SWITCH:  v = tgt_r;
      spi_sw_pkg::ADDR_ERR_CFG: v = {5'h00, cfg_r};
      spi_sw_pkg::ADDR_ERR_FLG: v = {5'h00, flg_r};
      spi_sw_pkg::ADDR_BURST:   v = {7'h00, burst_r};
      spi_sw_pkg::ADDR_DAISY:   v = {7'h00, daisy_r};
      default:                  v = 8'h00;
    endcase
    return v;
  endfunction : rd_data

  ////////////////////////////////////////////////////////////////////////////
  // Serial decode: next values
  always_comb begin
    spi_sw_pkg::cmd_type cmd;
    spi_sw_pkg::err_type set;
    spi_sw_pkg::err_type clr;
    logic                do_wr;
    logic [4:0]          cnt_inc;
    cmd        = '0;
    set        = '0;
    clr        = '0;
    do_wr      = 1'b0;
    cnt_inc    = cnt_r + 5'h01;
    sclk_d_nxt = pins_s.sclk;
    cs_d_nxt   = pins_s.cs_n;
    cnt_nxt    = cnt_r;
    ncmd_nxt   = ncmd_r;
    sh_nxt     = sh_r;
    out_nxt    = out_r;
    sdo_nxt    = sdo_r;
    pend_nxt   = pend_r;
    pend_v_nxt = pend_v_r;
    cfg_nxt    = cfg_r;
    burst_nxt  = burst_r;
    daisy_nxt  = daisy_r;
    tgt_nxt    = tgt_r;
    tgt_new    = 1'b0;

    if (cs_fall) begin
      // New frame: clear counters and output
      cnt_nxt    = 5'h00;
      ncmd_nxt   = 2'h0;
      out_nxt    = 8'h00;
      sdo_nxt    = 1'b0;
      pend_v_nxt = 1'b0;
    end else if (rise) begin
      // Most significant bit first, flag arrives first
      sh_nxt  = {sh_r[22:0], pins_s.sdi};
      cnt_nxt = cnt_inc;
      if (!daisy_r && cnt_inc == 5'(spi_sw_pkg::HDR_BITS)
          && sh_nxt[spi_sw_pkg::HDR_BITS-1]) begin
        // Read: load data for the coming falling edges
        out_nxt = rd_data(sh_nxt[6:0]);
      end
      if (cnt_inc == flen) begin
        cnt_nxt = 5'h00;
        if (ncmd_r != 2'h3) begin
          ncmd_nxt = ncmd_r + 2'h1;
        end
        if (!daisy_r) begin
          cmd = cfg_r.crc ? sh_nxt[23:8] : sh_nxt[15:0];
          set.crc  = cfg_r.crc &&
                     spi_sw_pkg::crc8(cmd) != sh_nxt[7:0];
          set.addr = cfg_r.addr && !addr_ok(cmd.addr);
          if (!cmd.rw && !set.crc && !set.addr) begin
            if (burst_r) begin
              do_wr = 1'b1;
            end else begin
              pend_nxt   = cmd;
              pend_v_nxt = (ncmd_r == 2'h0);
            end
          end
        end
      end
    end else if (fall) begin
      // Chain passes input on, else read data shifts out
      if (daisy_r) begin
        sdo_nxt = sh_r[spi_sw_pkg::DAISY_BITS-1];
      end else begin
        sdo_nxt = out_r[7];
        out_nxt = {out_r[6:0], 1'b0};
      end
    end else if (cs_rise) begin
      // Frame end: count check, then held write
      set.sclk = cfg_r.sclk && (cnt_r != 5'h00 ||
                 (!burst_r && !daisy_r && ncmd_r != 2'h1));
      if (daisy_r && !set.sclk && ncmd_r != 2'h0) begin
        tgt_nxt = sh_r[7:0];
        tgt_new = 1'b1;
      end
      if (!burst_r && !daisy_r && pend_v_r && !set.sclk) begin
        cmd   = pend_r;
        do_wr = 1'b1;
      end
      pend_v_nxt = 1'b0;
    end

    // Apply one accepted write
    if (do_wr) begin
      case (cmd.addr)
        spi_sw_pkg::ADDR_SWITCH: begin
          tgt_nxt = cmd.data;
          tgt_new = 1'b1;
        end
        spi_sw_pkg::ADDR_ERR_CFG: begin
          cfg_nxt = cmd.data[2:0];
        end
        spi_sw_pkg::ADDR_ERR_FLG: begin
          clr = cmd.data[2:0];
        end
        spi_sw_pkg::ADDR_BURST: begin
          burst_nxt = cmd.data[spi_sw_pkg::MODE_EN_POS];
        end
        spi_sw_pkg::ADDR_DAISY: begin
          daisy_nxt = cmd.data[spi_sw_pkg::MODE_EN_POS];
          // Entry frame holds no chain slice; its end must not latch one
          ncmd_nxt  = 2'h0;
        end
        default: begin
          tgt_nxt = tgt_r;
        end
      endcase
    end

    // Sticky flags, a new error wins over a clear
    flg_nxt = (flg_r & ~clr) | set;
  end

  // Serial decode: registers
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // Hardware reset returns to address mode
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
      cnt_r    <= 5'h00;
      ncmd_r   <= 2'h0;
      sh_r     <= 24'h000000;
      out_r    <= 8'h00;
      sdo_r    <= 1'b0;
      pend_r   <= '0;
      pend_v_r <= 1'b0;
      cfg_r    <= spi_sw_pkg::ERR_CFG_RST;
      flg_r    <= spi_sw_pkg::ERR_FLG_RST;
      burst_r  <= 1'b0;
      daisy_r  <= 1'b0;
      tgt_r    <= spi_sw_pkg::SWITCH_RST;
    end else begin
      sclk_d_r <= sclk_d_nxt;
      cs_d_r   <= cs_d_nxt;
      cnt_r    <= cnt_nxt;
      ncmd_r   <= ncmd_nxt;
      sh_r     <= sh_nxt;
      out_r    <= out_nxt;
      sdo_r    <= sdo_nxt;
      pend_r   <= pend_nxt;
      pend_v_r <= pend_v_nxt;
      cfg_r    <= cfg_nxt;
      flg_r    <= flg_nxt;
      burst_r  <= burst_nxt;
      daisy_r  <= daisy_nxt;
      tgt_r    <= tgt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-before-close sequencer
  typedef enum logic { SW_IDLE, SW_OPENING } sw_state_type;

  sw_state_type    st_r,  st_nxt;
  logic [N_SW-1:0] sw_r,  sw_nxt;       // Switch drives
  logic [7:0]      gap_r, gap_nxt;      // Gap countdown

  // Next values; a new pattern restarts the gap from what stays closed
  always_comb begin
    st_nxt  = st_r;
    sw_nxt  = sw_r;
    gap_nxt = gap_r;
    case (st_r)
      SW_IDLE: begin
        if (tgt_new) begin
          // Opening first avoids shorting two sources
          sw_nxt  = sw_r & tgt_nxt[N_SW-1:0];
          gap_nxt = 8'(GAP_CYC);
          st_nxt  = SW_OPENING;
        end
      end
      SW_OPENING: begin
        if (tgt_new) begin
          sw_nxt  = sw_r & tgt_nxt[N_SW-1:0];
          gap_nxt = 8'(GAP_CYC);
        end else if (gap_r == 8'h01) begin
          sw_nxt = tgt_r[N_SW-1:0];
          st_nxt = SW_IDLE;
        end else begin
          gap_nxt = gap_r - 8'h01;
        end
      end
      default: begin
        st_nxt = SW_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r  <= SW_IDLE;
      sw_r  <= '0;
      gap_r <= 8'h00;
    end else begin
      st_r  <= st_nxt;
      sw_r  <= sw_nxt;
      gap_r <= gap_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_sdo         = sdo_r;
  assign o_sdo_oe_n    = ~sel;     // Drive only while selected
  assign o_switch_on   = sw_r;
  assign o_err_flags   = flg_r;
  assign o_err_cfg     = cfg_r;
  assign o_burst_mode  = burst_r;
  assign o_daisy_mode  = daisy_r;
  assign o_switch_busy = (st_r == SW_OPENING);

endmodule : spi_switch_control_port

// *** hw/spi_sw_pkg.sv ***
package spi_sw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CORE_CLK_MHZ  = 100;  // Core clock rate
  localparam int OPEN_GAP_NS   = 100;  // Least open-to-close gap
  // Least time, rounded up to whole core cycles
  localparam int OPEN_GAP_CYC  = (OPEN_GAP_NS * CORE_CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int CMD_BITS      = 16;   // Address-mode command length
  localparam int CRC_BITS      = 8;    // Optional trailing checksum
  localparam int DAISY_BITS    = 8;    // Per-device slice in a chain
  localparam int HDR_BITS      = 8;    // Flag plus address
  localparam int RW_POS        = 15;   // Read flag position in command
  localparam logic [7:0] CRC_POLY = 8'h07;  // x^8+x^2+x+1
  localparam logic [7:0] CRC_INIT = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses (7-bit)
  localparam logic [6:0] ADDR_SWITCH  = 7'h01;  // Switch data
  localparam logic [6:0] ADDR_ERR_CFG = 7'h02;  // Error check enables
  localparam logic [6:0] ADDR_ERR_FLG = 7'h03;  // Error flags, write 1 clr
  localparam logic [6:0] ADDR_BURST   = 7'h05;  // Burst mode enable
  localparam logic [6:0] ADDR_DAISY   = 7'h06;  // Daisy-chain enable

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int ERR_SCLK_POS  = 0;
  localparam int ERR_ADDR_POS  = 1;
  localparam int ERR_CRC_POS   = 2;
  localparam int MODE_EN_POS   = 0;
  localparam logic [7:0] SWITCH_RST  = 8'h00;  // All switches open
  localparam logic [2:0] ERR_CFG_RST = 3'h3;   // Count, address on
  localparam logic [2:0] ERR_FLG_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       rw;     // 1 = read
    logic [6:0] addr;
    logic [7:0] data;
  } cmd_type;

  typedef struct packed {
    logic crc;
    logic addr;
    logic sclk;
  } err_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } pins_type;

  // Checksum over one command, most significant bit first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8

endpackage : spi_sw_pkg

// *** hw/sync_bits.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for a group of independent levels
module sync_bits #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  // Levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;  // First stage, read only by second stage

  // Both stages take constants under reset
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : sync_bits

// *** tb/spi_ctrl_model.sv ***
`timescale 1ns/1ps
// Far-side serial controller; link clock stands still between frames
module spi_ctrl_model (
  // Time base
  input  wire logic i_clk,
  // Serial pins
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  localparam int HALF = 8;  // 80 ns half period, well under the top rate

  ////////////////////////////////////////////////////////////////////////////
  // Idle lines at time zero
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  // One select-framed transfer of n bits; cpol picks mode 0 or 3
  task automatic frame(input logic [31:0] bits, input int n,
                       input bit cpol, output logic [31:0] rx);
    rx = 32'h00000000;
    o_sclk = cpol;
    repeat (HALF) @(negedge i_clk);
    o_cs_n = 1'b0;  // One select per command, or per burst
    repeat (HALF) @(negedge i_clk);
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_sdi  = bits[i];  // Flag, address, data, MSB first
      repeat (HALF) @(negedge i_clk);
      o_sclk = 1'b1;
      rx = {rx[30:0], i_sdo};  // Output taken on the rise
      repeat (HALF) @(negedge i_clk);
    end
    o_sclk = cpol;
    repeat (HALF) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_sdi  = ~o_sdi;  // Released data line shows no stale value
  endtask : frame
endmodule : spi_ctrl_model

// *** tb/spi_switch_control_port_checker.sv ***
`timescale 1ns/1ps
// Port-level watch on the control port
module spi_switch_control_port_checker #(
  parameter int N_SW    = 8,
  parameter int GAP_CYC = 10
) (
  input wire logic                i_core_clk,
  input wire logic                i_resetn,
  input wire logic                i_sclk,
  input wire logic                i_cs_n,
  input wire logic                i_sdi,
  input wire logic                o_sdo,
  input wire logic                o_sdo_oe_n,
  input wire logic [N_SW-1:0]     o_switch_on,
  input wire spi_sw_pkg::err_type o_err_flags,
  input wire spi_sw_pkg::err_type o_err_cfg,
  input wire logic                o_burst_mode,
  input wire logic                o_daisy_mode,
  input wire logic                o_switch_busy
);
  logic [15:0] busy_cnt_r;    // Cycles busy has stood
  logic [15:0] busy_cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Busy length counter
  always_comb begin
    busy_cnt_nxt = o_switch_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_reset_values: assert property (
    $rose(i_resetn) |-> o_switch_on == '0 && o_err_flags == 3'h0 &&
    o_err_cfg == 3'h3 && !o_burst_mode && !o_daisy_mode)
    else $error("Outputs differ from reset values");
  a_oe_idle: assert property (i_cs_n [*4] |-> o_sdo_oe_n)
    else $error("Output driven while deselected");
  a_oe_active: assert property ((!i_cs_n) [*4] |-> !o_sdo_oe_n)
    else $error("Output not driven while selected");
  a_close_at_end: assert property (
    |(o_switch_on & ~$past(o_switch_on)) |-> $fell(o_switch_busy))
    else $error("Switch closed outside gap end");
  a_gap_length: assert property (
    $fell(o_switch_busy) |-> busy_cnt_r >= GAP_CYC)
    else $error("Open-to-close gap too short");
  a_switch_quiet: assert property (
    !o_switch_busy && !$past(o_switch_busy) |-> $stable(o_switch_on))
    else $error("Switches moved without sequencer");
  a_regs_quiet: assert property (i_cs_n [*8] |->
    $stable(o_err_cfg) && $stable(o_err_flags) && $stable(o_burst_mode))
    else $error("Register changed with no frame");
  a_sdo_hold: assert property (
    (i_sclk && !i_cs_n) [*6] |-> $stable(o_sdo))
    else $error("Serial output moved while clock high");
  a_daisy_sticky: assert property ($past(o_daisy_mode) |-> o_daisy_mode)
    else $error("Chain mode left without reset");

  // Main scenarios reached
  c_gap: cover property ($fell(o_switch_busy));
  c_crc: cover property (o_err_flags.crc);
  c_burst: cover property (o_burst_mode && !i_cs_n);
endmodule : spi_switch_control_port_checker

bind spi_switch_control_port spi_switch_control_port_checker #(
  .N_SW(N_SW), .GAP_CYC(GAP_CYC)) u_checker (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_sclk(i_sclk),
  .i_cs_n(i_cs_n), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
  .o_switch_on(o_switch_on), .o_err_flags(o_err_flags),
  .o_err_cfg(o_err_cfg), .o_burst_mode(o_burst_mode),
  .o_daisy_mode(o_daisy_mode), .o_switch_busy(o_switch_busy));

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam int GAP = 4;  // Short gap keeps the run brief
  logic clk, rstn, sclk, cs_n, sdi, sdo, oe_n, burst, daisy, busy;
  logic [7:0] sw, sw_seen, cur, d;
  logic [31:0] rx;
  logic crc_on, mode3;
  spi_sw_pkg::err_type flags, cfg;
  logic [7:0] exp_q[$];  // Expected switch steps
  int n_errors, num_checks, cyc;

  spi_switch_control_port #(.N_SW(8), .GAP_CYC(GAP)) u_spi_switch_control_port (
    .i_core_clk(clk), .i_resetn(rstn), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe_n(oe_n), .o_switch_on(sw),
    .o_err_flags(flags), .o_err_cfg(cfg), .o_burst_mode(burst),
    .o_daisy_mode(daisy), .o_switch_busy(busy));
  spi_ctrl_model u_spi_ctrl_model (.i_clk(clk), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and run limit
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  task automatic chk_regs(input logic [2:0] c, f, input logic [1:0] m);
    check8({5'h00, cfg}, {5'h00, c});
    check8({5'h00, flags}, {5'h00, f});
    check8({6'h00, burst, daisy}, {6'h00, m});
  endtask : chk_regs

  // Own checksum, MSB first
  function automatic logic [7:0] crc_of(input logic [15:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? spi_sw_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc_of

  // Opens land first, full pattern after the gap
  task automatic put_sw(input logic [7:0] v);
    if ((cur & v) != cur) exp_q.push_back(cur & v);
    if ((cur & v) != v) exp_q.push_back(v);
    cur = v;
  endtask : put_sw

  // One frame, checksum added when on; waits sync plus gap
  task automatic cmd(input logic [31:0] c, input int n, input bit bad);
    logic [31:0] w;
    w = crc_on ? {8'h00, c[15:0], crc_of(c[15:0]) ^ {7'h00, bad}} : c;
    u_spi_ctrl_model.frame(w, crc_on ? 24 : n, mode3, rx);
    repeat (GAP + 12) @(negedge clk);
    check8(8'(exp_q.size()), 8'h00);
  endtask : cmd

  task automatic do_reset;
    rstn = 1'b0;
    if (cur != 8'h00) exp_q.push_back(8'h00);
    cur = 8'h00;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk_regs(3'h3, 3'h0, 2'h0);
  endtask : do_reset

  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Switch watcher: each change takes the oldest note
  always @(negedge clk) begin
    if (sw !== sw_seen) begin
      check8(sw, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
      sw_seen = sw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {crc_on, mode3, cur, sw_seen} = 18'h00000;
    void'($urandom(8));
    do_reset();
    put_sw(8'h01);
    cmd(32'h0101, 16, 0);
    put_sw(8'h02);
    cmd(32'h0102, 16, 0);
    for (int i = 0; i < 2; i++) begin
      mode3 = 1'(i);
      cmd({17'h00001, spi_sw_pkg::ADDR_SWITCH, 8'h00}, 16, 0);
      check8(rx[7:0], cur);
      d = 8'($urandom());
      put_sw(d);
      cmd({17'h0, spi_sw_pkg::ADDR_SWITCH, d}, 16, 0);
    end
    cmd({17'h0, spi_sw_pkg::ADDR_SWITCH, 8'hFF}, 15, 0);
    chk_regs(3'h3, 3'h1, 2'h0);
    cmd({17'h00001, spi_sw_pkg::ADDR_ERR_FLG, 8'h00}, 16, 0);
    check8(rx[7:0], 8'h01);
    cmd({17'h0, 7'h7F, 8'hFF}, 16, 0);
    chk_regs(3'h3, 3'h3, 2'h0);
    cmd({17'h0, spi_sw_pkg::ADDR_ERR_FLG, 8'h07}, 16, 0);
    cmd({1'b0, spi_sw_pkg::ADDR_SWITCH, 8'hAA,
         1'b0, spi_sw_pkg::ADDR_SWITCH, 8'h55}, 32, 0);
    chk_regs(3'h3, 3'h1, 2'h0);
    cmd({17'h0, spi_sw_pkg::ADDR_ERR_FLG, 8'h07}, 16, 0);
    cmd({17'h0, spi_sw_pkg::ADDR_ERR_CFG, 8'h05}, 16, 0);
    crc_on = 1'b1;
    cmd({17'h0, 7'h7F, 8'hFF}, 16, 0);
    chk_regs(3'h5, 3'h0, 2'h0);
    cmd({17'h0, spi_sw_pkg::ADDR_SWITCH, 8'hFF}, 16, 1);
    chk_regs(3'h5, 3'h4, 2'h0);
    put_sw(8'h81);
    cmd({17'h0, spi_sw_pkg::ADDR_SWITCH, 8'h81}, 16, 0);
    cmd({17'h0, spi_sw_pkg::ADDR_ERR_FLG, 8'h07}, 16, 0);
    cmd({17'h0, spi_sw_pkg::ADDR_ERR_CFG, 8'h03}, 16, 0);
    crc_on = 1'b0;
    cmd({17'h0, spi_sw_pkg::ADDR_BURST, 8'h01}, 16, 0);
    d = 8'($urandom());
    put_sw(d ^ 8'h0F);
    put_sw(d);
    cmd({1'b0, spi_sw_pkg::ADDR_SWITCH, d ^ 8'h0F,
         1'b0, spi_sw_pkg::ADDR_SWITCH, d}, 32, 0);
    chk_regs(3'h3, 3'h0, 2'h2);
    cmd({17'h0, spi_sw_pkg::ADDR_DAISY, 8'h01}, 16, 0);
    put_sw(8'h3C);
    cmd(32'hA53C, 16, 0);
    check8(rx[7:0], 8'hA5);
    chk_regs(3'h3, 3'h0, 2'h3);
    do_reset();
    put_sw(8'h01);
    cmd(32'h0101, 16, 0);
    print_verdict();
  end
endmodule : testbench
